// ===== hdl/exec_subset_pkg.sv
/*
 * Shared constants for the execute-subset block: opcode and function codes,
 * coprocessor branch selectors, exception causes and widths.
 * Assumes a single 100 MHz core clock and a synchronous active-low reset.
 */
package exec_subset_pkg;
    localparam int XLEN = 64;
    localparam logic [63:0] PC_RESET = 64'hffff_ffff_bfc0_0000;
    localparam logic [63:0] PC_STEP = 64'h0000_0000_0000_0004;
    // primary opcodes
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_ADD_IMMEDIATE_TRAPPING_TRAP = 6'h08;
    localparam logic [5:0] OP_ADD_IMMEDIATE_TRAPPING_NOTRAP = 6'h09;
    localparam logic [5:0] OP_LOGICAL_AND_IMMEDIATE = 6'h0c;
    localparam logic [5:0] OP_COP0 = 6'h10;
    // special function codes
    localparam logic [5:0] FN_JR = 6'h08;
    localparam logic [5:0] FN_JALR = 6'h09;
    localparam logic [5:0] FN_ADD_TRAP = 6'h20;
    localparam logic [5:0] FN_ADD_NOTRAP = 6'h21;
    localparam logic [5:0] FN_AND = 6'h24;
    // coprocessor sub-operations
    localparam logic [4:0] COP_MF = 5'h00;
    localparam logic [4:0] COP_MT = 5'h04;
    localparam logic [4:0] COP_BC = 5'h08;
    localparam logic [4:0] BC_FALSE = 5'h00;
    localparam logic [4:0] BC_FALSE_LIKELY = 5'h02;
    localparam logic [4:0] LINK_REG = 5'h1f;
    // exception causes
    localparam logic [4:0] EXC_NONE = 5'h00;
    localparam logic [4:0] EXC_ADDR_FETCH = 5'h04;
    localparam logic [4:0] EXC_RESERVED = 5'h0a;
    localparam logic [4:0] EXC_COP_UNUSABLE = 5'h0b;
    localparam logic [4:0] EXC_OVERFLOW = 5'h0c;
endpackage

// ===== hdl/gpr_file.sv
/*
 * General register file: 31 stored entries of 64 bits plus a fixed zero at address 0, two read ports, one write port.
 * Assumes the core clock and synchronous active-low reset of its parent.
 */
`timescale 1ns/1ps
module gpr_file (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [4:0] rd_addr_a_i,
    input wire logic [4:0] rd_addr_b_i,
    output logic [63:0] rd_data_a_o,
    output logic [63:0] rd_data_b_o,
    input wire logic wr_en_i,
    input wire logic [4:0] wr_addr_i,
    input wire logic [63:0] wr_data_i
);
    logic [63:0] regs_reg [1:31];
    wire wr_hit = wr_en_i && (wr_addr_i != 5'h00);

    // entry zero does not exist, so it reads zero and a write is dropped
    assign rd_data_a_o = (rd_addr_a_i == 5'h00) ? 64'h0 : regs_reg[rd_addr_a_i];
    assign rd_data_b_o = (rd_addr_b_i == 5'h00) ? 64'h0 : regs_reg[rd_addr_b_i];

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            for (int i = 1; i < 32; i++) begin
                regs_reg[i] <= 64'h0;
            end
        end else if (wr_hit) begin
            regs_reg[wr_addr_i] <= wr_data_i;
        end
    end
endmodule

// ===== hdl/exec_subset.sv
/*
 * Single-issue execute stage for a subset of the instruction set: adds, ANDs,
 * register jumps, system-coprocessor moves and the condition-false branches,
 * with delay-slot tracking and precise exception reporting.
 * Assumes one instruction word per cycle while instr_valid_i is high, and that
 * the fetch side follows pc_o on the cycle after it changes.
 * A jump placed in a delay slot is not detected; its outcome is left undefined.
 * No vector: an exception sends pc_o to the return address, the handler lives outside.
 */
`timescale 1ns/1ps
module exec_subset (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic mode64_i,
    input wire logic cop0_usable_i,
    input wire logic cop0_condition_i,
    input wire logic ext_exc_i,
    input wire logic [63:0] cop0_rd_data_i,
    output logic [63:0] pc_o,
    output logic exc_o,
    output logic [4:0] exc_cause_o,
    output logic [63:0] exception_return_pc_o,
    output logic exc_in_slot_o,
    output logic nullified_o,
    output logic cop0_wr_o,
    output logic [4:0] cop0_addr_o,
    output logic [63:0] cop0_wr_data_o,
    output logic [63:0] dbg_rs_data_o
);
    // instruction fields
    wire [5:0] opcode = instr_i[31:26];
    wire [4:0] source_reg_a = instr_i[25:21];
    wire [4:0] source_reg_b = instr_i[20:16];
    wire [4:0] dest_reg = instr_i[15:11];
    wire [5:0] funct = instr_i[5:0];
    wire [15:0] imm = instr_i[15:0];

    logic [63:0] pc_reg;
    logic in_slot_reg;
    logic [63:0] branch_pc_reg;
    logic redirect_reg;
    logic [63:0] redirect_tgt_reg;
    logic nullify_reg;
    logic cond_prev_reg;
    logic fetch_misalign_reg;
    logic exc_reg;
    logic [4:0] cause_reg;
    logic [63:0] epc_reg;
    logic exc_slot_reg;
    logic nullified_reg;
    logic cop0_wr_reg;
    logic [4:0] cop0_addr_reg;
    logic [63:0] cop0_data_reg;
    logic [63:0] dbg_reg;

    wire [63:0] rs_val;
    wire [63:0] rt_val;
    wire gpr_we;
    wire [4:0] gpr_waddr;
    wire [63:0] gpr_wdata;

    gpr_file u_gpr (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .rd_addr_a_i(source_reg_a),
        .rd_addr_b_i(source_reg_b),
        .rd_data_a_o(rs_val),
        .rd_data_b_o(rt_val),
        .wr_en_i(gpr_we),
        .wr_addr_i(gpr_waddr),
        .wr_data_i(gpr_wdata)
    );

    // decode
    wire is_special = (opcode == exec_subset_pkg::OP_SPECIAL);
    wire is_add_r = is_special && (funct == exec_subset_pkg::FN_ADD_TRAP || funct == exec_subset_pkg::FN_ADD_NOTRAP);
    wire is_and_r = is_special && (funct == exec_subset_pkg::FN_AND);
    wire is_jr = is_special && (funct == exec_subset_pkg::FN_JR);
    wire is_jalr = is_special && (funct == exec_subset_pkg::FN_JALR);
    wire is_add_immediate_trapping = (opcode == exec_subset_pkg::OP_ADD_IMMEDIATE_TRAPPING_TRAP) || (opcode == exec_subset_pkg::OP_ADD_IMMEDIATE_TRAPPING_NOTRAP);
    wire is_logical_and_immediate = (opcode == exec_subset_pkg::OP_LOGICAL_AND_IMMEDIATE);
    wire is_cop0 = (opcode == exec_subset_pkg::OP_COP0);
    // only move-to and move-from touch coprocessor registers
    wire is_mfc0 = is_cop0 && (source_reg_a == exec_subset_pkg::COP_MF);
    wire is_mtc0 = is_cop0 && (source_reg_a == exec_subset_pkg::COP_MT);
    wire is_bc = is_cop0 && (source_reg_a == exec_subset_pkg::COP_BC);
    wire is_bcf = is_bc && (source_reg_b == exec_subset_pkg::BC_FALSE);
    wire is_bcfl = is_bc && (source_reg_b == exec_subset_pkg::BC_FALSE_LIKELY);
    // other coprocessor sub-operations fall through to the reserved cause
    wire trapping = (is_add_r && funct == exec_subset_pkg::FN_ADD_TRAP) || (opcode == exec_subset_pkg::OP_ADD_IMMEDIATE_TRAPPING_TRAP);
    wire known = is_add_r || is_and_r || is_jr || is_jalr || is_add_immediate_trapping || is_logical_and_immediate || is_mfc0 || is_mtc0
        || is_bcf || is_bcfl;

    // adder: 32-bit sum, sign-extended in 64-bit mode, zero-extended otherwise
    wire [31:0] sext_imm = {{16{imm[15]}}, imm};
    wire [31:0] add_b = is_add_immediate_trapping ? sext_imm : rt_val[31:0];
    wire [31:0] sum32 = rs_val[31:0] + add_b;
    wire [63:0] sum_sx = {{32{sum32[31]}}, sum32};
    // carry into bit 31 differs from carry out of it
    wire ovf_raw = (rs_val[31] == add_b[31]) && (sum32[31] != rs_val[31]);
    wire ovf = ovf_raw && trapping && (is_add_r || is_add_immediate_trapping);
    wire [63:0] sum_out = mode64_i ? sum_sx : {32'h0, sum32};
    wire [63:0] logical_and_immediate_out = {48'h0, imm & rs_val[15:0]};
    wire [63:0] and_out = rs_val & rt_val;

    // a nullified slot keeps its pc step but writes nothing and faults only on ext_exc_i
    wire live = instr_valid_i && !nullify_reg;
    wire cop_unusable = live && (is_bcf || is_bcfl || is_mfc0 || is_mtc0) && !cop0_usable_i;
    wire reserved = live && !known;
    wire fetch_fault = live && fetch_misalign_reg;
    wire any_exc = fetch_fault || ext_exc_i || cop_unusable || reserved || (live && ovf);
    wire [4:0] cause_next = fetch_fault ? exec_subset_pkg::EXC_ADDR_FETCH
        : cop_unusable ? exec_subset_pkg::EXC_COP_UNUSABLE
        : reserved ? exec_subset_pkg::EXC_RESERVED
        : (live && ovf) ? exec_subset_pkg::EXC_OVERFLOW
        : exec_subset_pkg::EXC_NONE;
    wire commit = live && !any_exc;

    // register writeback; dropped on any exception
    assign gpr_we = commit && (is_add_r || is_and_r || is_add_immediate_trapping || is_logical_and_immediate || is_jalr || is_mfc0);
    assign gpr_waddr = (is_add_immediate_trapping || is_logical_and_immediate || is_mfc0) ? source_reg_b : dest_reg;
    // link skips the delay slot
    assign gpr_wdata = is_jalr ? (pc_reg + 64'h8)
        : is_mfc0 ? cop0_rd_data_i
        : is_logical_and_immediate ? logical_and_immediate_out
        : is_and_r ? and_out
        : sum_out;

    // branch target from delay-slot address
    // offset counts words, so two zero bits are appended
    wire [63:0] boff = {{46{imm[15]}}, imm, 2'b00};
    wire [63:0] slot_pc = pc_reg + exec_subset_pkg::PC_STEP;
    wire [63:0] bc_target = slot_pc + boff;
    // condition is the value sampled in the previous instruction
    wire bc_taken = !cond_prev_reg;
    wire jump_now = commit && (is_jr || is_jalr || ((is_bcf || is_bcfl) && bc_taken));
    wire [63:0] jump_tgt = (is_jr || is_jalr) ? rs_val : bc_target;
    wire is_ctl = is_jr || is_jalr || is_bcf || is_bcfl;
    // faulting slot reports the branch address
    wire [63:0] epc_next = in_slot_reg ? branch_pc_reg : pc_reg;
    // next fetch address: a pending redirect lands only after the slot has run
    wire [63:0] seq_pc = redirect_reg ? redirect_tgt_reg : slot_pc;

    assign pc_o = pc_reg;
    assign exc_o = exc_reg;
    assign exc_cause_o = cause_reg;
    assign exception_return_pc_o = epc_reg;
    assign exc_in_slot_o = exc_slot_reg;
    assign nullified_o = nullified_reg;
    assign cop0_wr_o = cop0_wr_reg;
    assign cop0_addr_o = cop0_addr_reg;
    assign cop0_wr_data_o = cop0_data_reg;
    assign dbg_rs_data_o = dbg_reg;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pc_reg <= exec_subset_pkg::PC_RESET;
            in_slot_reg <= 1'b0;
            branch_pc_reg <= 64'h0;
            redirect_reg <= 1'b0;
            redirect_tgt_reg <= 64'h0;
            nullify_reg <= 1'b0;
            cond_prev_reg <= 1'b0;
            fetch_misalign_reg <= 1'b0;
        end else if (instr_valid_i) begin
            // stalls keep the sample; a nullified slot still counts as the previous instruction
            cond_prev_reg <= cop0_condition_i;
            if (any_exc) begin
                // resume at the return address: the branch for a faulting slot, so branch and slot run again
                pc_reg <= epc_next;
                in_slot_reg <= 1'b0;
                redirect_reg <= 1'b0;
                nullify_reg <= 1'b0;
                fetch_misalign_reg <= 1'b0;
            end else begin
                // the slot runs, then the redirect applies
                pc_reg <= seq_pc;
                // the fault waits for the target fetch, so the jump and its slot still complete
                fetch_misalign_reg <= redirect_reg && (redirect_tgt_reg[1:0] != 2'b00);
                in_slot_reg <= live && is_ctl;
                branch_pc_reg <= pc_reg;
                redirect_reg <= jump_now;
                redirect_tgt_reg <= jump_tgt;
                nullify_reg <= live && is_bcfl && !bc_taken;
            end
        end
    end

    // the exception record only moves on a taken exception, so a handler reads it stable
    wire exc_take = instr_valid_i && any_exc;
    wire mt_take = instr_valid_i && commit && is_mtc0;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            exc_reg <= 1'b0;
            cause_reg <= exec_subset_pkg::EXC_NONE;
            epc_reg <= 64'h0;
            exc_slot_reg <= 1'b0;
            nullified_reg <= 1'b0;
            cop0_wr_reg <= 1'b0;
            cop0_addr_reg <= 5'h00;
            cop0_data_reg <= 64'h0;
            dbg_reg <= 64'h0;
        end else begin
            exc_reg <= exc_take;
            nullified_reg <= instr_valid_i && nullify_reg;
            cop0_wr_reg <= mt_take;
            dbg_reg <= rs_val;
            if (exc_take) begin
                cause_reg <= cause_next;
                epc_reg <= epc_next;
                exc_slot_reg <= in_slot_reg;
            end
            if (mt_take) begin
                cop0_addr_reg <= dest_reg;
                cop0_data_reg <= rt_val;
            end
        end
    end
endmodule

// ===== verification/exec_subset_props.sv
/* port checker for exec_subset, bound below to every instance.
   assumes one clock domain with the synchronous active-low reset. */
`timescale 1ns/1ps
module exec_subset_props (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic instr_valid_i,
    input wire logic [31:0] instr_i,
    input wire logic cop0_usable_i,
    input wire logic ext_exc_i,
    input wire logic [63:0] pc_o,
    input wire logic exc_o,
    input wire logic [4:0] exc_cause_o,
    input wire logic [63:0] exception_return_pc_o,
    input wire logic nullified_o,
    input wire logic cop0_wr_o,
    input wire logic [4:0] cop0_addr_o,
    input wire logic [63:0] dbg_rs_data_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // aligned issue with no external fault, so no other cause can win
    wire logic clean = instr_valid_i && !ext_exc_i && pc_o[1:0] == 2'b00;
    wire logic is_cop = instr_i[31:26] == exec_subset_pkg::OP_COP0;
    wire logic no_trap = instr_i[31:26] == exec_subset_pkg::OP_ADD_IMMEDIATE_TRAPPING_NOTRAP
        || (instr_i[31:26] == exec_subset_pkg::OP_SPECIAL && instr_i[5:0] == exec_subset_pkg::FN_ADD_NOTRAP);
    redirect_epc_a: assert property (exc_o |-> pc_o == exception_return_pc_o)
        else $error("pc not sent to return pc");
    cause_hold_a: assert property (!exc_o |-> $stable(exc_cause_o) && $stable(exception_return_pc_o))
        else $error("cause or return pc moved without exception");
    stall_hold_a: assert property (!instr_valid_i |=> $stable(pc_o) && !exc_o && !nullified_o)
        else $error("state moved during stall");
    ext_exc_a: assert property (instr_valid_i && ext_exc_i |=> exc_o)
        else $error("external exception lost");
    misfetch_a: assert property (instr_valid_i && !ext_exc_i && pc_o[1:0] != 2'b00 |=> exc_o
        && exc_cause_o == exec_subset_pkg::EXC_ADDR_FETCH && exception_return_pc_o == $past(pc_o))
        else $error("misaligned fetch not faulted");
    unusable_a: assert property (clean && is_cop && instr_i[25:21] == exec_subset_pkg::COP_BC && !cop0_usable_i
        |=> exc_o && exc_cause_o == exec_subset_pkg::EXC_COP_UNUSABLE)
        else $error("unusable coprocessor branch not faulted");
    no_trap_a: assert property (clean && no_trap |=> !exc_o)
        else $error("non-trapping add raised exception");
    move_to_a: assert property (clean && is_cop && cop0_usable_i && instr_i[25:21] == exec_subset_pkg::COP_MT
        |=> cop0_wr_o && cop0_addr_o == $past(instr_i[15:11]))
        else $error("move-to not committed");
    zero_reg_a: assert property (instr_valid_i && instr_i[25:21] == 5'h00 |=> dbg_rs_data_o == 64'h0)
        else $error("register zero not zero");
    cover property (nullified_o);
    cover property (cop0_wr_o);
    cover property (exc_o && exc_cause_o == exec_subset_pkg::EXC_ADDR_FETCH);
endmodule
bind exec_subset exec_subset_props props_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .cop0_usable_i(cop0_usable_i), .ext_exc_i(ext_exc_i),
    .pc_o(pc_o), .exc_o(exc_o), .exc_cause_o(exc_cause_o), .exception_return_pc_o(exception_return_pc_o),
    .nullified_o(nullified_o), .cop0_wr_o(cop0_wr_o), .cop0_addr_o(cop0_addr_o), .dbg_rs_data_o(dbg_rs_data_o));

// ===== verification/tb_exec_subset.sv
/* self-checking bench for exec_subset: issues instruction words, reads registers back
   through dbg_rs_data_o. assumes the checker is bound to the dut. */
`timescale 1ns/1ps
module tb_exec_subset;
    logic core_clk_i = 1'b0, resetn_i = 1'b0, instr_valid_i = 1'b0, mode64_i = 1'b1;
    logic cop0_usable_i = 1'b1, cop0_condition_i = 1'b0, ext_exc_i = 1'b0;
    logic [31:0] instr_i = 32'h0;
    logic [63:0] cop0_rd_data_i = 64'h0, exp_pc, p;
    logic [63:0] pc_o, exception_return_pc_o, cop0_wr_data_o, dbg_rs_data_o;
    logic exc_o, exc_in_slot_o, nullified_o, cop0_wr_o;
    logic [4:0] exc_cause_o, cop0_addr_o;
    int error_cnt = 0, compares = 0;
    localparam logic [31:0] NOP = 32'h0000_0021;
    exec_subset dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .mode64_i(mode64_i), .cop0_usable_i(cop0_usable_i), .cop0_condition_i(cop0_condition_i),
        .ext_exc_i(ext_exc_i), .cop0_rd_data_i(cop0_rd_data_i), .pc_o(pc_o), .exc_o(exc_o),
        .exc_cause_o(exc_cause_o), .exception_return_pc_o(exception_return_pc_o), .exc_in_slot_o(exc_in_slot_o),
        .nullified_o(nullified_o), .cop0_wr_o(cop0_wr_o), .cop0_addr_o(cop0_addr_o),
        .cop0_wr_data_o(cop0_wr_data_o), .dbg_rs_data_o(dbg_rs_data_o));
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] rr(input logic [5:0] fn, input logic [4:0] d, s, t);
        return {exec_subset_pkg::OP_SPECIAL, s, t, d, 5'h00, fn};
    endfunction
    function automatic logic [31:0] ri(input logic [5:0] op, input logic [4:0] t, s, input logic [15:0] imm);
        return {op, s, t, imm};
    endfunction
    // every call starts just after an edge and ends just after the edge that takes the word
    task automatic run(input logic [31:0] w);
        instr_i = w;
        instr_valid_i = 1'b1;
        @(posedge core_clk_i);
        #1;
        exp_pc = exp_pc + 64'h4;
    endtask
    task automatic do_reset;
        instr_valid_i = 1'b0;
        resetn_i = 1'b0;
        repeat (12) @(posedge core_clk_i);
        #1;
        resetn_i = 1'b1;
        exp_pc = exec_subset_pkg::PC_RESET;
    endtask
    task automatic load(input logic [4:0] r, input logic [63:0] v);
        cop0_rd_data_i = v;
        run(ri(exec_subset_pkg::OP_COP0, r, exec_subset_pkg::COP_MF, 16'h0));
    endtask
    task automatic rdchk(input logic [4:0] r, input logic [63:0] v);
        run(rr(exec_subset_pkg::FN_AND, 5'd0, r, 5'd0));
        chk(dbg_rs_data_o, v);
    endtask
    task automatic exc_chk(input logic [4:0] cause, input logic [63:0] back);
        chk(exc_o, 1'b1);
        chk(exc_cause_o, cause);
        exp_pc = exp_pc - back;
        chk(exception_return_pc_o, exp_pc);
        chk(pc_o, exp_pc);
    endtask
    task automatic t_adds;
        load(5'd3, 64'h7fff_ffff);
        run(ri(exec_subset_pkg::OP_ADD_IMMEDIATE_TRAPPING_NOTRAP, 5'd1, 5'd0, 16'h8000));
        run(rr(exec_subset_pkg::FN_ADD_TRAP, 5'd4, 5'd3, 5'd3));
        exc_chk(exec_subset_pkg::EXC_OVERFLOW, 64'h4);
        rdchk(5'd4, 64'h0);
        rdchk(5'd1, 64'hffff_ffff_ffff_8000);
        run(rr(exec_subset_pkg::FN_ADD_NOTRAP, 5'd4, 5'd3, 5'd3));
        chk(exc_o, 1'b0);
        rdchk(5'd4, 64'hffff_ffff_ffff_fffe);
        run(rr(exec_subset_pkg::FN_ADD_TRAP, 5'd5, 5'd3, 5'd1));
        rdchk(5'd5, 64'h7fff_7fff);
        run(ri(exec_subset_pkg::OP_ADD_IMMEDIATE_TRAPPING_TRAP, 5'd5, 5'd3, 16'h0001));
        exc_chk(exec_subset_pkg::EXC_OVERFLOW, 64'h4);
        rdchk(5'd5, 64'h7fff_7fff);
        mode64_i = 1'b0;
        run(rr(exec_subset_pkg::FN_ADD_NOTRAP, 5'd6, 5'd3, 5'd3));
        mode64_i = 1'b1;
        rdchk(5'd6, 64'hffff_fffe);
    endtask
    task automatic t_logic;
        load(5'd7, 64'hffff_ffff_ffff_ffff);
        run(rr(exec_subset_pkg::FN_AND, 5'd8, 5'd7, 5'd3));
        run(ri(exec_subset_pkg::OP_LOGICAL_AND_IMMEDIATE, 5'd9, 5'd7, 16'h8001));
        run(ri(exec_subset_pkg::OP_ADD_IMMEDIATE_TRAPPING_NOTRAP, 5'd0, 5'd7, 16'h0005));
        rdchk(5'd8, 64'h7fff_ffff);
        rdchk(5'd9, 64'h8001);
        rdchk(5'd0, 64'h0);
        run(32'hfc00_0000);
        exc_chk(exec_subset_pkg::EXC_RESERVED, 64'h4);
    endtask
    task automatic t_slot_exc;
        load(5'd11, 64'h2000);
        run(rr(exec_subset_pkg::FN_JR, 5'd0, 5'd11, 5'd0));
        chk(pc_o, exp_pc);
        ext_exc_i = 1'b1;
        run(NOP);
        ext_exc_i = 1'b0;
        exc_chk(exec_subset_pkg::EXC_NONE, 64'h8);
        chk(exc_in_slot_o, 1'b1);
        run(rr(exec_subset_pkg::FN_JR, 5'd0, 5'd11, 5'd0));
        run(NOP);
        exp_pc = 64'h2000;
        chk(pc_o, exp_pc);
        load(5'd16, 64'h3000);
        p = exp_pc;
        run(rr(exec_subset_pkg::FN_JALR, 5'd31, 5'd16, 5'd0));
        run(NOP);
        exp_pc = 64'h3000;
        chk(pc_o, exp_pc);
        rdchk(5'd31, p + 64'h8);
    endtask
    task automatic t_branch;
        run(NOP);
        p = exp_pc;
        run(ri(exec_subset_pkg::OP_COP0, exec_subset_pkg::BC_FALSE, exec_subset_pkg::COP_BC, 16'h0004));
        cop0_condition_i = 1'b1;
        run(NOP);
        exp_pc = p + 64'h14;
        chk(pc_o, exp_pc);
        run(ri(exec_subset_pkg::OP_COP0, exec_subset_pkg::BC_FALSE, exec_subset_pkg::COP_BC, 16'h0004));
        run(ri(exec_subset_pkg::OP_ADD_IMMEDIATE_TRAPPING_NOTRAP, 5'd14, 5'd0, 16'h0002));
        chk(pc_o, exp_pc);
        run(ri(exec_subset_pkg::OP_COP0, exec_subset_pkg::BC_FALSE_LIKELY, exec_subset_pkg::COP_BC, 16'h0004));
        cop0_condition_i = 1'b0;
        run(ri(exec_subset_pkg::OP_ADD_IMMEDIATE_TRAPPING_NOTRAP, 5'd13, 5'd0, 16'h0001));
        chk(nullified_o, 1'b1);
        p = exp_pc;
        run(ri(exec_subset_pkg::OP_COP0, exec_subset_pkg::BC_FALSE_LIKELY, exec_subset_pkg::COP_BC, 16'hfffe));
        run(ri(exec_subset_pkg::OP_ADD_IMMEDIATE_TRAPPING_NOTRAP, 5'd12, 5'd0, 16'h0001));
        exp_pc = p - 64'h4;
        chk(pc_o, exp_pc);
        chk(nullified_o, 1'b0);
        rdchk(5'd13, 64'h0);
        rdchk(5'd12, 64'h1);
        rdchk(5'd14, 64'h2);
    endtask
    task automatic t_cop;
        cop0_usable_i = 1'b0;
        for (int i = 0; i < 2; i++) begin
            run(ri(exec_subset_pkg::OP_COP0, i[1] ? 5'h0 : 5'h0 | {3'h0, i[0], 1'b0}, exec_subset_pkg::COP_BC, 16'h4));
            exc_chk(exec_subset_pkg::EXC_COP_UNUSABLE, 64'h4);
        end
        cop0_usable_i = 1'b1;
        load(5'd15, 64'h1234_5678_9abc_def0);
        run(ri(exec_subset_pkg::OP_COP0, 5'd15, exec_subset_pkg::COP_MT, {5'd9, 11'h0}));
        chk(cop0_wr_o, 1'b1);
        chk(cop0_addr_o, 5'd9);
        chk(cop0_wr_data_o, 64'h1234_5678_9abc_def0);
        instr_valid_i = 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
        chk(pc_o, exp_pc);
    endtask
    task automatic t_misfetch;
        load(5'd10, 64'h1002);
        run(rr(exec_subset_pkg::FN_JR, 5'd0, 5'd10, 5'd0));
        run(NOP);
        exp_pc = 64'h1002;
        run(NOP);
        exc_chk(exec_subset_pkg::EXC_ADDR_FETCH, 64'h4);
    endtask
    initial begin
        repeat (3000) @(posedge core_clk_i);
        error_cnt++;
        end_sim();
    end
    initial begin
        do_reset();
        chk(pc_o, exp_pc);
        chk({exc_o, nullified_o, cop0_wr_o}, 64'h0);
        t_adds();
        t_logic();
        t_slot_exc();
        t_branch();
        t_cop();
        t_misfetch();
        do_reset();
        chk(pc_o, exp_pc);
        rdchk(5'd3, 64'h0);
        end_sim();
    end
endmodule
